// File: src/cgl_consts.vh
// Function
// - d flip-flop: even is data, odd gates
// - jk flip-flop: hold, clear, set, toggle
// - d latch follows data while gate high
// - rs latch: set, reset, both forbidden
// - mode field codes 0 to 4, rest reserved
// - clock select makes input two the clock
// - pair element uses even table clock
// - input two reads low when clocking
// - outputs are events, events are inputs
// - standby without clock forces clocked outputs low
// - decoding keeps running in idle sleep
// - unit control: bit 6 standby, bit 0 enable
// - filter field: none, synchronizer, full filter
// - pin enable bit 3 drives dedicated pin
// - bit 7 edge, bit 6 clock, bit 0 enable
// - input one source coding
// - input zero coding differs at 5 and 8 to b
// - input two coding differs at 5 and 8 to b
// - eight-bit truth register per table
// - index is input two, one, zero
// - spi and serial routed only as master
// - even table disable clears pair element
`ifndef CGL_CONSTS_VH
`define CGL_CONSTS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define CGL_OFF_UNIT_CTRL   4'h0
`define CGL_OFF_SEQ_SELECT  4'h1
`define CGL_OFF_T0_CTRL     4'h5
`define CGL_OFF_T0_SEL_LOW  4'h6
`define CGL_OFF_T0_SEL_HIGH 4'h7
`define CGL_OFF_T0_TRUTH    4'h8
`define CGL_OFF_T1_CTRL     4'h9
`define CGL_OFF_T1_SEL_LOW  4'ha
`define CGL_OFF_T1_SEL_HIGH 4'hb
`define CGL_OFF_T1_TRUTH    4'hc

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define CGL_RESET_VALUE     8'h00
`define CGL_MASK_UNIT_CTRL  8'h41
`define CGL_MASK_SEQ_SELECT 8'h0f
`define CGL_MASK_T_CTRL     8'hf9
`define CGL_MASK_SEL_HIGH   8'h0f

// ****************************************************************
// field positions
// ****************************************************************
`define CGL_BIT_UNIT_EN     0
`define CGL_BIT_RUN_STDBY   6
`define CGL_BIT_T_EN        0
`define CGL_BIT_T_PIN_OE    3
`define CGL_BIT_T_FILT_LO   4
`define CGL_BIT_T_FILT_HI   5
`define CGL_BIT_T_CLK_SEL   6
`define CGL_BIT_T_EDGE      7

// ****************************************************************
// mode and filter codes
// ****************************************************************
`define CGL_SEQ_OFF         4'h0
`define CGL_SEQ_DFF         4'h1
`define CGL_SEQ_JK          4'h2
`define CGL_SEQ_LATCH       4'h3
`define CGL_SEQ_RS          4'h4
`define CGL_FILT_NONE       2'h0
`define CGL_FILT_SYNC       2'h1
`define CGL_FILT_FULL       2'h2

// ****************************************************************
// input source codes
// ****************************************************************
`define CGL_SRC_MASK        4'h0
`define CGL_SRC_FEEDBACK    4'h1
`define CGL_SRC_LINK        4'h2
`define CGL_SRC_EVENT_LINE_ZERO      4'h3
`define CGL_SRC_EVENT_LINE_ONE      4'h4
`define CGL_SRC_PIN         4'h5
`define CGL_SRC_CMP0        4'h6
`define CGL_SRC_CAPT0       4'h7
`define CGL_SRC_MAIN_TIMER  4'h8
`define CGL_SRC_CTL_TIMER   4'h9
`define CGL_SRC_SERIAL      4'ha
`define CGL_SRC_SPI         4'hb
`define CGL_SRC_CMP1        4'hc
`define CGL_SRC_CAPT1       4'hd
`define CGL_SRC_CMP2        4'he
`define CGL_SRC_RESERVED    4'hf

`endif

// File: src/cgl_custom_glue_logic.v
`timescale 1ns/1ps
`include "cgl_consts.vh"

module cgl_custom_glue_logic (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       standby_mode,
    input  wire       event_line_zero,
    input  wire       event_line_one,
    input  wire [5:0] table_pin_in,
    input  wire       comparator_zero,
    input  wire       comparator_one,
    input  wire       comparator_two,
    input  wire       capture_timer_zero,
    input  wire       capture_timer_one,
    input  wire [2:0] main_timer_channel,
    input  wire       control_timer_output_a,
    input  wire       control_timer_output_b,
    input  wire       serial_port_clock,
    input  wire       serial_port_tx,
    input  wire       serial_port_master,
    input  wire       spi_sck,
    input  wire       spi_mosi,
    input  wire       spi_miso,
    input  wire       spi_master,
    output reg  [1:0] table_output_event,
    output reg  [1:0] table_pin_out,
    output reg  [1:0] table_pin_oe
);

    // ****************************************************************
    // control registers
    // ****************************************************************
    reg  [7:0] unit_control_q;
    reg  [7:0] pair_sequential_select_q;
    wire       unit_en;
    wire       run_in_standby;
    wire       clock_removed;
    wire       seq_state;
    wire [1:0] tick;
    wire [1:0] result;
    wire [1:0] table_on;

    assign unit_en        = unit_control_q[`CGL_BIT_UNIT_EN];
    assign run_in_standby = unit_control_q[`CGL_BIT_RUN_STDBY];
    assign clock_removed  = standby_mode && !run_in_standby;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            unit_control_q           <= `CGL_RESET_VALUE;
            pair_sequential_select_q <= `CGL_RESET_VALUE;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `CGL_OFF_UNIT_CTRL)
            begin
                unit_control_q <= reg_wdata & `CGL_MASK_UNIT_CTRL;
            end
            // mode field only changes while the even table is off
            if (reg_addr == `CGL_OFF_SEQ_SELECT && !gen_table[0].ctl_q[`CGL_BIT_T_EN])
            begin
                pair_sequential_select_q <= reg_wdata & `CGL_MASK_SEQ_SELECT;
            end
        end
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    // every outside source is asynchronous to clk, so all pass two stages
    // limitation: a pulse shorter than one clk period can be missed
    wire [24:0] raw_in;
    reg  [24:0] meta_q;
    reg  [24:0] sync_q;

    assign raw_in = {spi_master, spi_miso, spi_mosi, spi_sck,
                     serial_port_master, serial_port_tx, serial_port_clock,
                     control_timer_output_b, control_timer_output_a,
                     main_timer_channel, capture_timer_one, capture_timer_zero,
                     comparator_two, comparator_one, comparator_zero,
                     table_pin_in, event_line_one, event_line_zero};

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q <= 25'h0;
            sync_q <= 25'h0;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    wire       s_ev0      = sync_q[0];
    wire       s_ev1      = sync_q[1];
    wire [5:0] s_pin      = sync_q[7:2];
    wire       s_cmp0     = sync_q[8];
    wire       s_cmp1     = sync_q[9];
    wire       s_cmp2     = sync_q[10];
    wire       s_capt0    = sync_q[11];
    wire       s_capt1    = sync_q[12];
    wire [2:0] s_main     = sync_q[15:13];
    wire       s_ctl_a    = sync_q[16];
    wire       s_ctl_b    = sync_q[17];
    wire       s_ser_clk  = sync_q[18];
    wire       s_ser_tx   = sync_q[19];
    wire       s_ser_mst  = sync_q[20];
    wire       s_spi_sck  = sync_q[21];
    wire       s_spi_mosi = sync_q[22];
    wire       s_spi_miso = sync_q[23];
    wire       s_spi_mst  = sync_q[24];

    // ****************************************************************
    // lookup tables
    // ****************************************************************
    genvar n;
    generate
        for (n = 0; n < 2; n = n + 1)
        begin : gen_table
            localparam [3:0] OFF_CTRL = (n == 0) ? `CGL_OFF_T0_CTRL : `CGL_OFF_T1_CTRL;
            localparam [3:0] OFF_LOW  = (n == 0) ? `CGL_OFF_T0_SEL_LOW : `CGL_OFF_T1_SEL_LOW;
            localparam [3:0] OFF_HIGH = (n == 0) ? `CGL_OFF_T0_SEL_HIGH : `CGL_OFF_T1_SEL_HIGH;
            localparam [3:0] OFF_TRU  = (n == 0) ? `CGL_OFF_T0_TRUTH : `CGL_OFF_T1_TRUTH;

            reg  [7:0]  ctl_q;
            reg  [7:0]  sel_low_q;
            reg  [7:0]  sel_high_q;
            reg  [7:0]  truth_q;
            reg  [15:0] src0;
            reg  [15:0] src1;
            reg  [15:0] src2;
            wire        protect;

            // selects and truth bits are frozen while the table runs
            assign protect = ctl_q[`CGL_BIT_T_EN];

            always @(posedge clk)
            begin
                if (sys_rst)
                begin
                    ctl_q      <= `CGL_RESET_VALUE;
                    sel_low_q  <= `CGL_RESET_VALUE;
                    sel_high_q <= `CGL_RESET_VALUE;
                    truth_q    <= `CGL_RESET_VALUE;
                end
                else if (reg_wr)
                begin
                    if (reg_addr == OFF_CTRL)
                    begin
                        if (!protect)
                        begin
                            ctl_q <= reg_wdata & `CGL_MASK_T_CTRL;
                        end
                        else
                        begin
                            ctl_q[`CGL_BIT_T_EN] <= reg_wdata[`CGL_BIT_T_EN];
                        end
                    end
                    if (reg_addr == OFF_LOW && !protect)
                    begin
                        sel_low_q <= reg_wdata;
                    end
                    if (reg_addr == OFF_HIGH && !protect)
                    begin
                        sel_high_q <= reg_wdata & `CGL_MASK_SEL_HIGH;
                    end
                    if (reg_addr == OFF_TRU && !protect)
                    begin
                        truth_q <= reg_wdata;
                    end
                end
            end

            // one source vector per input; slots only differ at 5 and 8 to b
            always @*
            begin
                src0 = 16'h0000;
                src1 = 16'h0000;
                src2 = 16'h0000;
                src0[`CGL_SRC_FEEDBACK]   = seq_state;
                src0[`CGL_SRC_LINK]       = table_output_event[(n + 1) % 2];
                src0[`CGL_SRC_EVENT_LINE_ZERO]     = s_ev0;
                src0[`CGL_SRC_EVENT_LINE_ONE]     = s_ev1;
                src0[`CGL_SRC_CMP0]       = s_cmp0;
                src0[`CGL_SRC_CAPT0]      = s_capt0;
                src0[`CGL_SRC_CMP1]       = s_cmp1;
                src0[`CGL_SRC_CAPT1]      = s_capt1;
                src0[`CGL_SRC_CMP2]       = s_cmp2;
                src1 = src0;
                src2 = src0;
                src0[`CGL_SRC_PIN]        = s_pin[3 * n];
                src1[`CGL_SRC_PIN]        = s_pin[3 * n + 1];
                src2[`CGL_SRC_PIN]        = s_pin[3 * n + 2];
                src0[`CGL_SRC_MAIN_TIMER] = s_main[0];
                src1[`CGL_SRC_MAIN_TIMER] = s_main[1];
                src2[`CGL_SRC_MAIN_TIMER] = s_main[2];
                src0[`CGL_SRC_CTL_TIMER]  = s_ctl_a;
                src1[`CGL_SRC_CTL_TIMER]  = s_ctl_b;
                src2[`CGL_SRC_CTL_TIMER]  = s_ctl_a;
                src0[`CGL_SRC_SERIAL]     = s_ser_clk & s_ser_mst;
                src1[`CGL_SRC_SERIAL]     = s_ser_tx & s_ser_mst;
                src0[`CGL_SRC_SPI]        = s_spi_sck & s_spi_mst;
                src1[`CGL_SRC_SPI]        = s_spi_mosi & s_spi_mst;
                src2[`CGL_SRC_SPI]        = s_spi_miso & s_spi_mst;
            end

            assign table_on[n] = unit_en && ctl_q[`CGL_BIT_T_EN];

            cgl_table_unit u_table (
                .clk           (clk),
                .sys_rst       (sys_rst),
                .enable        (table_on[n]),
                .edge_en       (ctl_q[`CGL_BIT_T_EDGE]),
                .clk_sel       (ctl_q[`CGL_BIT_T_CLK_SEL]),
                .filter_sel    (ctl_q[`CGL_BIT_T_FILT_HI:`CGL_BIT_T_FILT_LO]),
                .sel0          (sel_low_q[3:0]),
                .sel1          (sel_low_q[7:4]),
                .sel2          (sel_high_q[3:0]),
                .truth         (truth_q),
                .src0          (src0),
                .src1          (src1),
                .src2          (src2),
                .clock_removed (clock_removed),
                .tick          (tick[n]),
                .result        (result[n])
            );
        end
    endgenerate

    // ****************************************************************
    // pair sequential element
    // ****************************************************************
    // disable clear is synchronous here: one clock keeps it glitch free
    wire [3:0] seq_mode;
    wire       seq_on;

    assign seq_mode = pair_sequential_select_q[3:0];
    assign seq_on   = (seq_mode == `CGL_SEQ_DFF) || (seq_mode == `CGL_SEQ_JK) ||
                      (seq_mode == `CGL_SEQ_LATCH) || (seq_mode == `CGL_SEQ_RS);

    cgl_seq_element u_seq (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .mode         (seq_mode),
        .even_in      (result[0]),
        .odd_in       (result[1]),
        .tick         (tick[0]),
        .even_enabled (table_on[0]),
        .state_q      (seq_state)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    reg [1:0] final_d;
    reg [1:0] clocked_use;
    integer   k;

    always @*
    begin
        final_d     = 2'h0;
        clocked_use = 2'h0;
        for (k = 0; k < 2; k = k + 1)
        begin
            clocked_use[k] = (k == 0) ? seq_on : 1'b0;
        end
        clocked_use[0] = clocked_use[0] ||
                         gen_table[0].ctl_q[`CGL_BIT_T_EDGE] ||
                         (gen_table[0].ctl_q[`CGL_BIT_T_FILT_HI:`CGL_BIT_T_FILT_LO] != `CGL_FILT_NONE);
        clocked_use[1] = gen_table[1].ctl_q[`CGL_BIT_T_EDGE] ||
                         (gen_table[1].ctl_q[`CGL_BIT_T_FILT_HI:`CGL_BIT_T_FILT_LO] != `CGL_FILT_NONE);
        final_d[0] = table_on[0] && (seq_on ? seq_state : result[0]);
        final_d[1] = table_on[1] && result[1];
        for (k = 0; k < 2; k = k + 1)
        begin
            if (clock_removed && clocked_use[k])
            begin
                final_d[k] = 1'b0;
            end
        end
    end

    // registered so link and feedback paths never form a loop
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            table_output_event <= 2'h0;
            table_pin_out      <= 2'h0;
            table_pin_oe       <= 2'h0;
        end
        else
        begin
            table_output_event <= final_d;
            table_pin_out      <= final_d;
            table_pin_oe       <= {gen_table[1].ctl_q[`CGL_BIT_T_PIN_OE],
                                   gen_table[0].ctl_q[`CGL_BIT_T_PIN_OE]};
        end
    end

    // ****************************************************************
    // register read
    // ****************************************************************
    // the bus never waits, so data always come exactly one cycle late
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `CGL_OFF_UNIT_CTRL:   reg_rdata <= unit_control_q;
                `CGL_OFF_SEQ_SELECT:  reg_rdata <= pair_sequential_select_q;
                `CGL_OFF_T0_CTRL:     reg_rdata <= gen_table[0].ctl_q;
                `CGL_OFF_T0_SEL_LOW:  reg_rdata <= gen_table[0].sel_low_q;
                `CGL_OFF_T0_SEL_HIGH: reg_rdata <= gen_table[0].sel_high_q;
                `CGL_OFF_T0_TRUTH:    reg_rdata <= gen_table[0].truth_q;
                `CGL_OFF_T1_CTRL:     reg_rdata <= gen_table[1].ctl_q;
                `CGL_OFF_T1_SEL_LOW:  reg_rdata <= gen_table[1].sel_low_q;
                `CGL_OFF_T1_SEL_HIGH: reg_rdata <= gen_table[1].sel_high_q;
                `CGL_OFF_T1_TRUTH:    reg_rdata <= gen_table[1].truth_q;
                default:              reg_rdata <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// File: src/cgl_seq_element.v
`timescale 1ns/1ps
`include "cgl_consts.vh"

module cgl_seq_element (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire [3:0] mode,
    input  wire       even_in,
    input  wire       odd_in,
    input  wire       tick,
    input  wire       even_enabled,
    output reg        state_q
);

    reg  clr_hold_q;
    wire clear;

    // reset stays asserted one cycle past the disable
    assign clear = !even_enabled || clr_hold_q;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            clr_hold_q <= 1'b0;
            state_q    <= 1'b0;
        end
        else
        begin
            clr_hold_q <= !even_enabled;
            if (clear)
            begin
                state_q <= 1'b0;
            end
            else
            begin
                case (mode)
                    `CGL_SEQ_DFF:
                    begin
                        if (tick && odd_in)
                        begin
                            state_q <= even_in;
                        end
                    end
                    `CGL_SEQ_JK:
                    begin
                        if (tick)
                        begin
                            case ({even_in, odd_in})
                                2'b01:   state_q <= 1'b0;
                                2'b10:   state_q <= 1'b1;
                                2'b11:   state_q <= ~state_q;
                                default: state_q <= state_q;
                            endcase
                        end
                    end
                    `CGL_SEQ_LATCH:
                    begin
                        if (odd_in)
                        begin
                            state_q <= even_in;
                        end
                    end
                    `CGL_SEQ_RS:
                    begin
                        // forbidden pair simply holds
                        if (even_in && !odd_in)
                        begin
                            state_q <= 1'b1;
                        end
                        else if (!even_in && odd_in)
                        begin
                            state_q <= 1'b0;
                        end
                    end
                    default:
                    begin
                        state_q <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// File: src/cgl_table_unit.v
`timescale 1ns/1ps
`include "cgl_consts.vh"

module cgl_table_unit (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        enable,
    input  wire        edge_en,
    input  wire        clk_sel,
    input  wire [1:0]  filter_sel,
    input  wire [3:0]  sel0,
    input  wire [3:0]  sel1,
    input  wire [3:0]  sel2,
    input  wire [7:0]  truth,
    input  wire [15:0] src0,
    input  wire [15:0] src1,
    input  wire [15:0] src2,
    input  wire        clock_removed,
    output wire        tick,
    output wire        result
);

    wire       in0;
    wire       in1;
    wire       raw2;
    wire       in2;
    wire       lookup_table;
    wire       filtered;
    reg        in2_prev_q;
    reg  [2:0] stage_q;
    reg        filt_q;
    reg        edge_prev_q;

    assign in0  = src0[sel0];
    assign in1  = src1[sel1];
    assign raw2 = src2[sel2];
    assign in2  = raw2 & ~clk_sel;
    // decode is pure logic, so it keeps refreshing in every sleep mode
    assign lookup_table  = truth[{in2, in1, in0}];

    // the edge of input two is a tick in clk, so there is one domain only
    assign tick = clk_sel ? (raw2 & ~in2_prev_q) : ~clock_removed;

    always @(posedge clk)
    begin
        if (sys_rst || !enable)
        begin
            in2_prev_q  <= 1'b0;
            stage_q     <= 3'h0;
            filt_q      <= 1'b0;
            edge_prev_q <= 1'b0;
        end
        else
        begin
            in2_prev_q <= raw2;
            if (tick)
            begin
                stage_q     <= {stage_q[1:0], lookup_table};
                edge_prev_q <= filtered;
                if (stage_q[2] == stage_q[1] && stage_q[1] == stage_q[0])
                begin
                    filt_q <= stage_q[2];
                end
            end
        end
    end

    // reserved filter code behaves as no filter
    assign filtered = (filter_sel == `CGL_FILT_SYNC) ? stage_q[1] :
                      (filter_sel == `CGL_FILT_FULL) ? filt_q : lookup_table;

    assign result = edge_en ? (filtered & ~edge_prev_q) : filtered;

endmodule

// File: test/cgl_custom_glue_logic_sva.sv
`timescale 1ns/1ps
module cgl_glue_sva (
    input wire       clk,
    input wire       sys_rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire [1:0] table_output_event,
    input wire [1:0] table_pin_out,
    input wire [1:0] table_pin_oe
);
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
// enable bits tracked from the bus, since the registers are not at the ports
reg en_q;
reg t0_q;
always @(posedge clk)
    en_q <= sys_rst ? 1'h0 : (reg_wr && reg_addr == 4'h0) ? reg_wdata[0] : en_q;
always @(posedge clk)
    t0_q <= sys_rst ? 1'h0 : (reg_wr && reg_addr == 4'h5) ? reg_wdata[0] : t0_q;
sequence s_wr(a); reg_wr && reg_addr == a; endsequence
sequence s_rd(a); reg_rd && reg_addr == a; endsequence
a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
a_hole_zero: assert property (reg_rd && reg_addr inside {4'h2, 4'h3, 4'h4, 4'hd, 4'he, 4'hf}
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
a_unit_bits: assert property (s_rd(4'h0) |=> (reg_rdata & 8'hbe) == 8'h00)
    else $error("unit control reserved bits set");
a_unit_back: assert property (s_wr(4'h0) ##1 s_rd(4'h0) |=>
    reg_rdata == ($past(reg_wdata, 2) & 8'h41)) else $error("unit control readback");
a_mode_back: assert property (!t0_q ##0 s_wr(4'h1) ##1 s_rd(4'h1) |=>
    reg_rdata == ($past(reg_wdata, 2) & 8'h0f)) else $error("mode field readback");
a_pin_copy: assert property (table_pin_out == table_output_event)
    else $error("pin output differs from event");
a_oe_cause: assert property ($changed(table_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("pin enable changed without write");
a_unit_off: assert property (!en_q [*3] |-> table_output_event == 2'h0)
    else $error("output while unit disabled");
endmodule
bind cgl_custom_glue_logic cgl_glue_sva cgl_glue_sva_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .table_output_event(table_output_event),
    .table_pin_out(table_pin_out), .table_pin_oe(table_pin_oe));

// File: test/cgl_periph_model.sv
`timescale 1ns/1ps
module cgl_periph_model (
    input  wire        clk,
    input  wire [5:0]  pin_req,
    output reg  [5:0]  pins,
    output reg  [18:0] misc
);
// ****************
// far-side sources
// ****************
// unused sources churn every cycle so a wrong selection cannot pass by luck
initial
begin
    pins = 6'h00;
    misc = 19'h00000;
end
always @(posedge clk)
begin
    pins <= pin_req;
    misc <= 19'($urandom);
end
endmodule

// File: test/tb_cgl_custom_glue_logic.sv
`timescale 1ns/1ps
module tb_cgl_custom_glue_logic;
reg         clk, sys_rst, reg_wr, reg_rd, standby_mode, look;
reg         rd_d = 1'h0;
reg  [3:0]  reg_addr;
reg  [7:0]  reg_wdata, truth;
reg  [5:0]  pin_req;
wire [7:0]  reg_rdata;
wire [1:0]  tev, tpo, toe;
wire [5:0]  pins;
wire [18:0] m;
logic [7:0] exp_rd[$];
logic [1:0] exp_out[$];
int         n_errors = 0, checks = 0, i, k;
cgl_periph_model cgl_periph_model_i (.clk(clk), .pin_req(pin_req), .pins(pins), .misc(m));
cgl_custom_glue_logic cgl_custom_glue_logic_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .standby_mode(standby_mode), .event_line_zero(m[0]),
    .event_line_one(m[1]), .table_pin_in(pins), .comparator_zero(m[2]),
    .comparator_one(m[3]), .comparator_two(m[4]), .capture_timer_zero(m[5]),
    .capture_timer_one(m[6]), .main_timer_channel(m[9:7]), .control_timer_output_a(m[10]),
    .control_timer_output_b(m[11]), .serial_port_clock(m[12]), .serial_port_tx(m[13]),
    .serial_port_master(m[14]), .spi_sck(m[15]), .spi_mosi(m[16]), .spi_miso(m[17]),
    .spi_master(m[18]), .table_output_event(tev), .table_pin_out(tpo), .table_pin_oe(toe));
initial
begin
    clk = 1'h0;
    forever #5 clk = ~clk;
end
task give_verdict;
begin
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
end
endtask
task cmp_byte(input logic [7:0] e, input logic [7:0] g);
begin
    checks++;
    if (g !== e)
    begin
        n_errors++;
        $display("[ERR] read data exp %h got %h", e, g);
    end
end
endtask
task cmp_oe(input logic [1:0] e, input logic [1:0] g);
begin
    checks++;
    if (g !== e)
    begin
        n_errors++;
        $display("[ERR] pin enable exp %b got %b", e, g);
    end
end
endtask
task cmp_bit(input logic [1:0] e, input logic [1:0] g);
begin
    checks++;
    if (g !== e)
    begin
        n_errors++;
        $display("[ERR] table output exp %b got %b", e, g);
    end
end
endtask
// for a read, d is the value expected back; call right after an edge,
// strobes stay up until the next task replaces or lowers them
task bus(input w, input [3:0] a, input [7:0] d);
begin
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w)
        exp_rd.push_back(d);
    @(posedge clk);
end
endtask
// pins pass the model, two sync stages and the output register
task probe(input [2:0] v, input [7:0] t, input o1);
begin
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    pin_req <= {3'h0, v};
    repeat (6) @(posedge clk);
    exp_out.push_back({o1, t[v]});
    look <= 1'h1;
    @(posedge clk);
    look <= 1'h0;
end
endtask
always @(posedge clk)
begin
    rd_d <= reg_rd;
    if (rd_d)
        cmp_byte(exp_rd.pop_front(), reg_rdata);
    if (look)
    begin
        cmp_bit(exp_out.pop_front(), tev);
        cmp_oe(2'h1, toe);
    end
end
initial
begin
    #200000;
    n_errors++;
    give_verdict;
end
initial
begin
    void'($urandom(61781));
    {sys_rst, reg_wr, reg_rd, standby_mode, look} = 5'h10;
    {reg_addr, reg_wdata, pin_req} = 18'h00000;
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    for (i = 0; i < 16; i++)
        bus(1'h0, i[3:0], 8'h00);
    bus(1'h1, 4'h2, 8'hff);
    bus(1'h0, 4'h2, 8'h00);
    bus(1'h1, 4'h0, 8'hff);
    bus(1'h0, 4'h0, 8'h41);
    bus(1'h1, 4'h1, 8'hf3);
    bus(1'h0, 4'h1, 8'h03);
    bus(1'h1, 4'h1, 8'h00);
    bus(1'h1, 4'h6, 8'h55);
    bus(1'h1, 4'h7, 8'hf5);
    bus(1'h0, 4'h7, 8'h05);
    for (k = 0; k < 2; k++)
    begin
        truth = 8'($urandom);
        standby_mode <= k[0];
        bus(1'h1, 4'h0, k[0] ? 8'h01 : 8'h41);
        bus(1'h1, 4'h5, 8'h00);
        bus(1'h1, 4'h8, truth);
        bus(1'h1, 4'h5, 8'h09);
        bus(1'h0, 4'h5, 8'h09);
        bus(1'h0, 4'h8, truth);
        for (i = 0; i < 8; i++)
            probe(i[2:0], truth, 1'h0);
    end
    bus(1'h1, 4'h5, 8'h08);
    bus(1'h1, 4'h1, 8'h03);
    bus(1'h1, 4'hc, 8'hff);
    bus(1'h1, 4'h9, 8'h01);
    bus(1'h1, 4'h5, 8'h09);
    probe(3'h5, 8'h00, 1'h1);
    standby_mode <= 1'h0;
    probe(3'h5, truth, 1'h1);
    bus(1'h1, 4'h0, 8'h00);
    bus(1'h1, 4'h5, 8'hff);
    bus(1'h0, 4'h5, 8'h09);
    probe(3'h7, 8'h00, 1'h0);
    repeat (3) @(posedge clk);
    give_verdict;
end
endmodule
